/* rtl/lpw_map.svh */
// Purpose: Offsets, field positions, reset values and timing for emitter/window timing
// Assumes: 16-bit registers reached through the decoded host register port
// Notes: Field map and timing counts
// Operation
// - Emitter pulse delayed by six-bit microsecond offset
// - Emitter pulse width five-bit microseconds, reset 1
// - Pulse period eight-bit microseconds, reset 8
// - Pulses per burst six-bit count, reset 1
// - Window fine offset in 31.25 ns steps
// - Window coarse offset in microsecond steps
// - Window width five-bit microseconds, reset 1
// - Frontend clock masked only when gate bit set
// - Multisample bit selects single or multiple samples
`ifndef LPW_MAP_SVH
`define LPW_MAP_SVH

`define LPW_ADDR_S_EMIT      8'h20
`define LPW_ADDR_S_PERIOD    8'h21
`define LPW_ADDR_N_EMIT      8'h22
`define LPW_ADDR_N_PERIOD    8'h23
`define LPW_ADDR_EMIT_GATE   8'h24
`define LPW_ADDR_S_WINDOW    8'h25
`define LPW_ADDR_N_WINDOW    8'h26
`define LPW_ADDR_FE_CTRL     8'h27

`define LPW_DELAY_LSB        0
`define LPW_DURATION_LSB     8
`define LPW_INTERVAL_LSB     0
`define LPW_COUNT_LSB        8
`define LPW_EMIT_GATE_BIT    8
`define LPW_FINE_LSB         0
`define LPW_COARSE_LSB       5
`define LPW_WWIDTH_LSB       11
`define LPW_FE_GATE_BIT      0
`define LPW_MULTI_BIT        1

`define LPW_RST_DELAY        6'h00
`define LPW_RST_DURATION     5'h01
`define LPW_RST_INTERVAL     8'h08
`define LPW_RST_COUNT        6'h01
`define LPW_RST_FINE         5'h00
`define LPW_RST_COARSE       6'h00
`define LPW_RST_WWIDTH       5'h01

`define LPW_CLK_PERIOD_PS    20000
`define LPW_US_PS            1000000
`define LPW_FINE_STEP_PS     31250
`define LPW_CYC_PER_US       (`LPW_US_PS / `LPW_CLK_PERIOD_PS)

`endif

/* rtl/lpw_pkg.sv */
// Purpose: Types for the emitter/window timing block
// Assumes: lpw_map.svh constants
// Notes: Whole state is one packed struct
package lpw_pkg;

	typedef enum logic [0:0] {
		LPW_IDLE = 1'b0,
		LPW_RUN  = 1'b1
	} lpw_state_type;

	typedef struct packed {
		lpw_state_type st;
		logic          mode;
		logic [15:0]   cyc;
		logic [5:0]    left;
		logic [5:0]    s_delay;
		logic [4:0]    s_duration;
		logic [7:0]    s_interval;
		logic [5:0]    s_count;
		logic [5:0]    n_delay;
		logic [4:0]    n_duration;
		logic [7:0]    n_interval;
		logic [5:0]    n_count;
		logic          emit_gate;
		logic [4:0]    s_fine;
		logic [5:0]    s_coarse;
		logic [4:0]    s_wwidth;
		logic [4:0]    n_fine;
		logic [5:0]    n_coarse;
		logic [4:0]    n_wwidth;
		logic          fe_gate;
		logic          multi;
		logic          emitter;
		logic          window;
		logic          fe_clk_en;
		logic          sample;
		logic [15:0]   rdata;
	} lpw_regs_type;

endpackage

/* rtl/lpw_timing.sv */
// Purpose: Emitter pulse train and frontend integration window generator
// Assumes: Register port already decoded from the host link, same clock
// Notes: Outputs lag the cycle counter by one clock, all registered
`timescale 1ns/10ps
`default_nettype none
`include "lpw_map.svh"

module lpw_timing (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic        near_mode_i,
	input  wire logic        burst_start_i,
	output logic      [15:0] reg_rdata_o,
	output logic             emitter_o,
	output logic             window_o,
	output logic             frontend_clk_en_o,
	output logic             sample_strobe_o,
	output logic             burst_busy_o
);
	import lpw_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Conversions

	function automatic logic [15:0] us2c(input logic [8:0] us);
		logic [31:0] p;
		p = 32'(us) * 32'(`LPW_CYC_PER_US);
		return p[15:0];
	endfunction

	// Rounds down: 31.25 ns is not a whole number of 20 ns clocks
	function automatic logic [15:0] fine2c(input logic [4:0] f);
		logic [31:0] p;
		p = (32'(f) * 32'(`LPW_FINE_STEP_PS)) / 32'(`LPW_CLK_PERIOD_PS);
		return p[15:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	lpw_regs_type r;
	lpw_regs_type next_r;

	logic [5:0]  a_delay;
	logic [4:0]  a_duration;
	logic [7:0]  a_interval;
	logic [4:0]  a_fine;
	logic [5:0]  a_coarse;
	logic [4:0]  a_wwidth;
	logic [15:0] off_c;
	logic [15:0] emit_end;
	logic [15:0] win_s;
	logic [15:0] win_e;
	logic [15:0] per_end;
	logic        last_cyc;

	// Parameter set follows the mode latched at burst start
	always_comb begin
		a_delay    = r.mode ? r.n_delay    : r.s_delay;
		a_duration = r.mode ? r.n_duration : r.s_duration;
		a_interval = r.mode ? r.n_interval : r.s_interval;
		a_fine     = r.mode ? r.n_fine     : r.s_fine;
		a_coarse   = r.mode ? r.n_coarse   : r.s_coarse;
		a_wwidth   = r.mode ? r.n_wwidth   : r.s_wwidth;
		off_c      = us2c({3'h0, a_delay});
		emit_end   = us2c(9'({3'h0, a_delay}) + 9'({4'h0, a_duration}));
		win_s      = us2c({3'h0, a_coarse}) + fine2c(a_fine);
		win_e      = win_s + us2c({4'h0, a_wwidth});
		// Zero period would stall the counter; treated as one microsecond
		per_end    = us2c((a_interval == 8'h00) ? 9'h001 : {1'b0, a_interval})
			- 16'h0001;
		// Greater-or-equal so a period shortened mid-burst still wraps
		last_cyc   = (r.cyc >= per_end);
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_r = r;
		next_r.sample = 1'b0;

		if (reg_wr_i) begin
			case (reg_addr_i)
				`LPW_ADDR_S_EMIT: begin
					next_r.s_delay    = reg_wdata_i[`LPW_DELAY_LSB +: 6];
					next_r.s_duration = reg_wdata_i[`LPW_DURATION_LSB +: 5];
				end
				`LPW_ADDR_S_PERIOD: begin
					next_r.s_interval = reg_wdata_i[`LPW_INTERVAL_LSB +: 8];
					next_r.s_count    = reg_wdata_i[`LPW_COUNT_LSB +: 6];
				end
				`LPW_ADDR_N_EMIT: begin
					next_r.n_delay    = reg_wdata_i[`LPW_DELAY_LSB +: 6];
					next_r.n_duration = reg_wdata_i[`LPW_DURATION_LSB +: 5];
				end
				`LPW_ADDR_N_PERIOD: begin
					next_r.n_interval = reg_wdata_i[`LPW_INTERVAL_LSB +: 8];
					next_r.n_count    = reg_wdata_i[`LPW_COUNT_LSB +: 6];
				end
				`LPW_ADDR_EMIT_GATE: begin
					next_r.emit_gate = reg_wdata_i[`LPW_EMIT_GATE_BIT];
				end
				`LPW_ADDR_S_WINDOW: begin
					next_r.s_fine   = reg_wdata_i[`LPW_FINE_LSB +: 5];
					next_r.s_coarse = reg_wdata_i[`LPW_COARSE_LSB +: 6];
					next_r.s_wwidth = reg_wdata_i[`LPW_WWIDTH_LSB +: 5];
				end
				`LPW_ADDR_N_WINDOW: begin
					next_r.n_fine   = reg_wdata_i[`LPW_FINE_LSB +: 5];
					next_r.n_coarse = reg_wdata_i[`LPW_COARSE_LSB +: 6];
					next_r.n_wwidth = reg_wdata_i[`LPW_WWIDTH_LSB +: 5];
				end
				`LPW_ADDR_FE_CTRL: begin
					next_r.fe_gate = reg_wdata_i[`LPW_FE_GATE_BIT];
					next_r.multi   = reg_wdata_i[`LPW_MULTI_BIT];
				end
				default: begin
				end
			endcase
		end

		// Reserved bits read back as zero
		if (reg_rd_i) begin
			case (reg_addr_i)
				`LPW_ADDR_S_EMIT:    next_r.rdata = {3'h0, r.s_duration, 2'h0, r.s_delay};
				`LPW_ADDR_S_PERIOD:  next_r.rdata = {2'h0, r.s_count, r.s_interval};
				`LPW_ADDR_N_EMIT:    next_r.rdata = {3'h0, r.n_duration, 2'h0, r.n_delay};
				`LPW_ADDR_N_PERIOD:  next_r.rdata = {2'h0, r.n_count, r.n_interval};
				`LPW_ADDR_EMIT_GATE: next_r.rdata = {7'h00, r.emit_gate, 8'h00};
				`LPW_ADDR_S_WINDOW:  next_r.rdata = {r.s_wwidth, r.s_coarse, r.s_fine};
				`LPW_ADDR_N_WINDOW:  next_r.rdata = {r.n_wwidth, r.n_coarse, r.n_fine};
				`LPW_ADDR_FE_CTRL:   next_r.rdata = {14'h0, r.multi, r.fe_gate};
				default:             next_r.rdata = 16'h0000;
			endcase
		end

		case (r.st)
			LPW_IDLE: begin
				next_r.emitter = 1'b0;
				next_r.window  = 1'b0;
				next_r.cyc     = 16'h0000;
				// Zero count means an empty burst, nothing starts
				if (burst_start_i) begin
					next_r.mode = near_mode_i;
					next_r.left = near_mode_i ? r.n_count : r.s_count;
					if ((near_mode_i ? r.n_count : r.s_count) != 6'h00) begin
						next_r.st = LPW_RUN;
					end
				end
			end
			LPW_RUN: begin
				next_r.emitter = (r.cyc >= off_c) && (r.cyc < emit_end)
					&& !r.emit_gate;
				next_r.window  = (r.cyc >= win_s) && (r.cyc < win_e);
				if (last_cyc) begin
					next_r.cyc    = 16'h0000;
					next_r.left   = r.left - 6'h01;
					next_r.sample = r.multi || (r.left == 6'h01);
					if (r.left == 6'h01) begin
						next_r.st = LPW_IDLE;
					end
				end else begin
					next_r.cyc = r.cyc + 16'h0001;
				end
			end
			default: begin
				next_r.st = LPW_IDLE;
			end
		endcase

		// Unmasked clock runs freely; masked clock only inside the window
		next_r.fe_clk_en = !r.fe_gate || next_r.window;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r            <= '0;
			r.st         <= LPW_IDLE;
			r.s_delay    <= `LPW_RST_DELAY;
			r.s_duration <= `LPW_RST_DURATION;
			r.s_interval <= `LPW_RST_INTERVAL;
			r.s_count    <= `LPW_RST_COUNT;
			r.n_delay    <= `LPW_RST_DELAY;
			r.n_duration <= `LPW_RST_DURATION;
			r.n_interval <= `LPW_RST_INTERVAL;
			r.n_count    <= `LPW_RST_COUNT;
			r.s_fine     <= `LPW_RST_FINE;
			r.s_coarse   <= `LPW_RST_COARSE;
			r.s_wwidth   <= `LPW_RST_WWIDTH;
			r.n_fine     <= `LPW_RST_FINE;
			r.n_coarse   <= `LPW_RST_COARSE;
			r.n_wwidth   <= `LPW_RST_WWIDTH;
			r.fe_clk_en  <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign reg_rdata_o       = r.rdata;
	assign emitter_o         = r.emitter;
	assign window_o          = r.window;
	assign frontend_clk_en_o = r.fe_clk_en;
	assign sample_strobe_o   = r.sample;
	assign burst_busy_o      = (r.st == LPW_RUN);

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_EMIT_START: assert property (
		$rose(emitter_o) |-> $past(r.cyc) == $past(off_c))
		else $error("Emitter rose away from its offset");

	AST_EMIT_END: assert property (
		$fell(emitter_o) && !$past(r.emit_gate) && $past(emit_end) <= $past(per_end)
		&& $past(r.st) == LPW_RUN |-> $past(r.cyc) == $past(emit_end))
		else $error("Emitter width wrong");

	AST_PERIOD_WRAP: assert property (
		r.st == LPW_RUN && last_cyc && r.left > 6'h01 |=> r.cyc == 16'h0000 && r.st == LPW_RUN)
		else $error("Period did not wrap");

	AST_BURST_LOAD: assert property (
		r.st == LPW_IDLE && burst_start_i && !near_mode_i
		|=> r.left == $past(r.s_count))
		else $error("Pulse count not loaded");

	AST_BURST_END: assert property (
		r.st == LPW_RUN && last_cyc && r.left == 6'h01 |=> !burst_busy_o)
		else $error("Burst did not end after last pulse");

	AST_WIN_START: assert property (
		$rose(window_o) |-> $past(r.cyc) == $past(win_s))
		else $error("Window opened at wrong offset");

	AST_WIN_END: assert property (
		$fell(window_o) && $past(win_e) <= $past(per_end) && $past(r.st) == LPW_RUN
		|-> $past(r.cyc) == $past(win_e))
		else $error("Window width wrong");

	AST_FE_UNMASKED: assert property (
		!r.fe_gate |=> frontend_clk_en_o)
		else $error("Frontend clock masked while gate off");

	AST_SINGLE_SAMPLE: assert property (
		sample_strobe_o && !$past(r.multi) |-> $past(r.left) == 6'h01 && !burst_busy_o)
		else $error("Extra sample in single mode");

	AST_MODE_HELD: assert property (
		r.st == LPW_RUN && $past(r.st) == LPW_RUN |-> $stable(r.mode))
		else $error("Mode changed inside a burst");

	// Outputs show the condition of the counter one clock earlier
	AST_EMIT_INSIDE: assert property (
		emitter_o |-> $past(r.cyc) >= $past(off_c) && $past(r.cyc) < $past(emit_end)
		&& !$past(r.emit_gate))
		else $error("Emitter on outside its pulse");

	AST_WIN_INSIDE: assert property (
		window_o |-> $past(r.cyc) >= $past(win_s) && $past(r.cyc) < $past(win_e))
		else $error("Window open outside its span");

	AST_FE_MASKED: assert property (
		r.fe_gate |=> frontend_clk_en_o == window_o)
		else $error("Masked frontend clock ran outside the window");

	AST_SAMPLE_AT_WRAP: assert property (
		sample_strobe_o |-> $past(last_cyc) && $past(r.st) == LPW_RUN)
		else $error("Sample strobe away from a period end");

	AST_IDLE_QUIET: assert property (
		r.st == LPW_IDLE |=> !emitter_o && !window_o)
		else $error("Emitter or window active outside a burst");

	// Mid-burst starts must leave length and mode alone
	AST_START_REFUSED: assert property (
		r.st == LPW_RUN && burst_start_i && !last_cyc |=> r.left == $past(r.left)
		&& r.mode == $past(r.mode))
		else $error("Start accepted during a burst");

	AST_NEAR_LOAD: assert property (
		r.st == LPW_IDLE && burst_start_i && near_mode_i
		|=> r.mode && r.left == $past(r.n_count))
		else $error("Near parameter set not latched");

	COV_NEAR_BURST: cover property (r.st == LPW_IDLE && burst_start_i && near_mode_i);
	COV_MULTI: cover property (sample_strobe_o && r.multi && burst_busy_o);
	COV_MASKED: cover property (r.fe_gate && $rose(frontend_clk_en_o));
	COV_GATED: cover property (r.emit_gate && burst_busy_o && r.cyc == off_c);
	COV_START_BUSY: cover property (burst_busy_o && burst_start_i);

endmodule

`default_nettype wire

/* verification/lpw_led_model.sv */
// Purpose: LED current sink and integrating front end seen from the pins
// Assumes: Single 50 MHz clock, clear pulsed with each burst start
// Notes: res_o 7..0: pulses, led rise, led width, window rise, window width,
//        lit-while-integrating cycles, samples taken, frontend clock cycles
`timescale 1ns/10ps
`default_nettype none

module lpw_led_model (
	input  wire logic              clk_i,
	input  wire logic              clear_i,
	input  wire logic              emitter_i,
	input  wire logic              window_i,
	input  wire logic              fe_clk_en_i,
	input  wire logic              strobe_i,
	output logic      [7:0][15:0]  res_o
);
	logic [15:0] t;
	logic [15:0] e_run;
	logic [15:0] w_run;
	logic        e_prev;
	logic        w_prev;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		e_prev <= emitter_i;
		w_prev <= window_i;
		if (clear_i) begin
			res_o <= '0;
			// Start cycle counts as one so offsets read as cycles after the start
			t     <= 16'h1;
			e_run <= 16'h0;
			w_run <= 16'h0;
		end else begin
			t     <= t + 16'h1;
			e_run <= emitter_i ? e_run + 16'h1 : 16'h0;
			w_run <= window_i ? w_run + 16'h1 : 16'h0;
			if (emitter_i && !e_prev) res_o[7] <= res_o[7] + 16'h1;
			// First rise only; later pulses share the same offset
			if (emitter_i && !e_prev && res_o[7] == 16'h0) res_o[6] <= t;
			if (!emitter_i && e_prev) res_o[5] <= e_run;
			if (window_i && !w_prev && res_o[4] == 16'h0) res_o[4] <= t;
			if (!window_i && w_prev) res_o[3] <= w_run;
			// Light only integrates while both are on
			res_o[2] <= res_o[2] + {15'h0, emitter_i & window_i};
			res_o[1] <= res_o[1] + {15'h0, strobe_i};
			res_o[0] <= res_o[0] + {15'h0, fe_clk_en_i};
		end
	end
endmodule

`default_nettype wire

/* verification/tb_lpw_timing.sv */
// Purpose: Self-checking bench for lpw_timing
// Assumes: 50 MHz clock, inputs driven 2 ns after the rising edge
// Notes: Burst timing is judged through the LED and front end model
`timescale 1ns/10ps
`default_nettype none

module tb_lpw_timing;
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic [7:0]       reg_addr_i = 8'h00;
	logic [15:0]      reg_wdata_i = 16'h0000;
	logic             reg_wr_i = 1'b0;
	logic             reg_rd_i = 1'b0;
	logic             near_mode_i = 1'b0;
	logic             burst_start_i = 1'b0;
	logic             clear = 1'b0;
	logic [15:0]      reg_rdata_o;
	logic             emitter_o;
	logic             window_o;
	logic             frontend_clk_en_o;
	logic             sample_strobe_o;
	logic             burst_busy_o;
	logic [7:0][15:0] res;
	int               n_fail = 0;
	int               total_checks = 0;
	int               cycles = 0;

	lpw_timing i_lpw_timing (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.near_mode_i(near_mode_i), .burst_start_i(burst_start_i), .reg_rdata_o(reg_rdata_o),
		.emitter_o(emitter_o), .window_o(window_o), .frontend_clk_en_o(frontend_clk_en_o),
		.sample_strobe_o(sample_strobe_o), .burst_busy_o(burst_busy_o));
	lpw_led_model i_lpw_led_model (.clk_i(clk_i), .clear_i(clear), .emitter_i(emitter_o),
		.window_i(window_o), .fe_clk_en_i(frontend_clk_en_o), .strobe_i(sample_strobe_o),
		.res_o(res));

	////////////////////////////////////////////////////////////////
	always #10 clk_i = ~clk_i;

	// Longest legal run is about 2700 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		#2 reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(posedge clk_i);
		#2 reg_wr_i = 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_i);
		#2 reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(posedge clk_i);
		#2 reg_rd_i = 1'b0;
		chk($sformatf("reg_%h", a), reg_rdata_o, e);
	endtask

	// A second start mid-burst must leave the burst length untouched
	task automatic run(input logic mode, input logic [15:0] busy_exp,
		input logic [7:0][15:0] exp);
		int n;
		@(posedge clk_i);
		#2 near_mode_i = mode;
		burst_start_i = 1'b1;
		clear = 1'b1;
		@(posedge clk_i);
		#2 burst_start_i = 1'b0;
		clear = 1'b0;
		n = 0;
		while (burst_busy_o === 1'b1 && n < 5000) begin
			n++;
			if (n == 10) burst_start_i = 1'b1;
			if (n == 11) burst_start_i = 1'b0;
			@(posedge clk_i);
			#2;
		end
		chk("busy_len", 16'(n), busy_exp);
		repeat (2) @(posedge clk_i);
		#2;
		for (int i = 7; i >= 0; i--) chk($sformatf("model_%0d", i), res[i], exp[i]);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic sc_reset_values();
		logic [8:0][15:0] tab;
		tab = {16'h0000, 16'h0000, 16'h0800, 16'h0800, 16'h0000,
			16'h0108, 16'h0100, 16'h0108, 16'h0100};
		chk("fe_clk_en", {15'h0, frontend_clk_en_o}, 16'h0001);
		for (int i = 0; i < 9; i++)
			rd_chk(8'h20 + 8'(i), tab[i]);
	endtask

	task automatic sc_register_masks();
		logic [8:0][15:0] tab;
		tab = {16'h0000, 16'h0003, 16'hFFFF, 16'hFFFF, 16'h0100,
			16'h3FFF, 16'h1F3F, 16'h3FFF, 16'h1F3F};
		for (int i = 0; i < 9; i++) wr(8'h20 + 8'(i), 16'hFFFF);
		for (int i = 0; i < 9; i++) rd_chk(8'h20 + 8'(i), tab[i]);
	endtask

	// Delay 2, width 3, period 10, two pulses; window 1 us + 16 fine steps, width 2
	task automatic sc_sample_burst();
		wr(8'h20, 16'h0302);
		wr(8'h21, 16'h020A);
		wr(8'h24, 16'h0000);
		wr(8'h25, 16'h1030);
		wr(8'h27, 16'h0003);
		run(1'b0, 16'd1000,
			{16'd2, 16'd102, 16'd150, 16'd77, 16'd100, 16'd150, 16'd2, 16'd200});
	endtask

	// Fine offset 31 steps rounds down to 48 clocks; sample set left different
	task automatic sc_near_burst();
		wr(8'h22, 16'h0100);
		wr(8'h23, 16'h0304);
		wr(8'h26, 16'h081F);
		wr(8'h27, 16'h0001);
		run(1'b1, 16'd600,
			{16'd3, 16'd2, 16'd50, 16'd50, 16'd50, 16'd6, 16'd1, 16'd150});
	endtask

	task automatic sc_emitter_gate();
		wr(8'h24, 16'h0100);
		run(1'b0, 16'd1000,
			{16'd0, 16'd0, 16'd0, 16'd77, 16'd100, 16'd0, 16'd1, 16'd200});
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		#2 rst_i = 1'b0;
		sc_reset_values();
		sc_register_masks();
		sc_sample_burst();
		sc_near_burst();
		sc_emitter_gate();
		final_report();
	end
endmodule

`default_nettype wire
